// [rtl/xbus_pkg.sv]
// What this block does
// - Port 0 open-drain; latch one floats pin.
// - Port 0 multiplexes address/data during external access.
// - Ports 1-3 quasi-bidirectional with weak pullups.
// - Port 2 carries high address when wide.
// - Port 2 address ones driven strongly high.
// - Narrow data access keeps port 2 latch.
// - Port 3 alternate functions, bits 0-5; bits 6-7 write/read strobes.
// - Address latch pulse marks port 0 address.
// - Address latch pulses at oscillator over six.
// - Each data access skips one latch pulse.
// - Code strobe twice per cycle, data skips two.
// - Lock bit one holds strap from reset.
// - Flash mode: port 0 takes/gives code bytes.
// - Flash mode: address from ports 1 and 2.
// - Flash mode: latch pin is program pulse input.
package xbus_pkg;

  localparam int PHASES_PER_MC = 12;
  localparam logic [3:0] PH_FIRST = 4'h0;
  localparam logic [3:0] PH_LAST = 4'hb;
  localparam logic [3:0] PH_ALE_A = 4'h0;
  localparam logic [3:0] PH_ALE_A_END = 4'h1;
  localparam logic [3:0] PH_ADDR_A_END = 4'h2;
  localparam logic [3:0] PH_STRB_A = 4'h3;
  localparam logic [3:0] PH_HALF_END = 4'h5;
  localparam logic [3:0] PH_ALE_B = 4'h6;
  localparam logic [3:0] PH_ALE_B_END = 4'h7;
  localparam logic [3:0] PH_ADDR_B_END = 4'h8;
  localparam logic [3:0] PH_STRB_B = 4'h9;
  localparam logic [3:0] PH_RW_START = 4'h1;
  localparam int RST_HOLD_MC = 2;
  localparam int RST_HOLD_TICKS = RST_HOLD_MC * PHASES_PER_MC;
  localparam int OSC_DIV_DEFAULT = 4;
  localparam int OSC_DIV_MIN = 4;
  localparam int SYNC_WIDTH = 35;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam int P3_WR_BIT = 6;
  localparam int P3_RD_BIT = 7;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_DADDR = 3'b010,
    ST_DSTRB = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] p0;
  } port_byte4_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xdata_req_t;

  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data;
  } flash_word_t;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_reset_val,
  output logic [WIDTH-1:0] o_level
);

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync needs WIDTH of at least one");
    end
  end

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;
  logic [1:0] fill_ff;

  // A change is accepted only once the second and third stages agree.
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_comb begin
        // While the stages still fill, take the second stage so the level is valid once filled.
        nxt_level[b] = (fill_ff != 2'h3) ? s2_ff[b] : ((s2_ff[b] == s3_ff[b]) ? s3_ff[b] : level_ff[b]);
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  // The reset value is shown until the stages hold real pin levels, so no false edge follows reset.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      fill_ff <= 2'h0;
    end else if (fill_ff != 2'h3) begin
      fill_ff <= fill_ff + 2'h1;
    end
  end

  assign o_level = (fill_ff == 2'h3) ? level_ff : i_reset_val;

endmodule // pin_sync

// [rtl/port_and_external_memory_bus.sv]
`timescale 1ns/1ps
module port_and_external_memory_bus #(
  parameter int OSC_DIV = xbus_pkg::OSC_DIV_DEFAULT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rst_pin,
  input wire logic i_external_fetch_strap_n,
  input wire logic i_lock_bit1,
  input wire logic i_program_pulse_in_mode,
  input wire logic i_verify_mode,
  input wire xbus_pkg::port_byte4_t i_latch,
  input wire logic [7:0] i_p3_alt_out,
  input wire logic [15:0] i_pc,
  input wire xbus_pkg::xdata_req_t i_xreq,
  input wire xbus_pkg::port_byte4_t i_pin,
  input wire logic i_ale_pin,
  input wire logic [7:0] i_flash_rdata,
  output xbus_pkg::port_byte4_t o_pin_out,
  output xbus_pkg::port_byte4_t o_pin_oe,
  output logic o_ale,
  output logic o_ale_oe,
  output logic o_code_read_strobe_n,
  output logic [7:0] o_code_byte,
  output logic o_code_valid,
  output logic o_xreq_taken,
  output logic o_data_done,
  output logic [7:0] o_rdata,
  output xbus_pkg::port_byte4_t o_pin_sync,
  output logic o_core_reset,
  output logic o_ext_exec,
  output xbus_pkg::flash_word_t o_flash,
  output logic o_flash_write
);
  import xbus_pkg::*;

  initial begin
    if (OSC_DIV < OSC_DIV_MIN) begin
      $error("OSC_DIV too small for the pin synchronisers");
    end
  end

  localparam logic [7:0] DIV_LAST = 8'(OSC_DIV - 1);
  localparam logic [4:0] RST_TICKS = 5'(RST_HOLD_TICKS);

  // Pin synchronisers.
  logic [SYNC_WIDTH-1:0] sync_level;
  port_byte4_t pin_s;
  logic rst_pin_s;
  logic ale_pin_s;
  logic strap_n_s;

  pin_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async({i_external_fetch_strap_n, i_ale_pin, i_rst_pin, i_pin}),
    .i_reset_val({1'b1, 1'b1, 1'b0, {4{PORT_RESET}}}),
    .o_level(sync_level)
  );

  assign pin_s = sync_level[31:0];
  assign rst_pin_s = sync_level[32];
  assign ale_pin_s = sync_level[33];
  assign strap_n_s = sync_level[34];

  // Oscillator tick, machine-cycle phase, reset pin qualification, strap hold.
  logic [7:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic [3:0] phase_ff, nxt_phase;
  logic [4:0] rst_cnt_ff, nxt_rst_cnt;
  logic core_reset_ff, nxt_core_reset;
  logic strap_held_ff, nxt_strap_held;
  logic strap_taken_ff, nxt_strap_taken;
  logic ext_exec;

  always_comb begin
    nxt_div = (div_ff == DIV_LAST) ? 8'h00 : div_ff + 8'h01;
    nxt_tick = (div_ff == DIV_LAST);
    nxt_phase = phase_ff;
    if (tick_ff) begin
      nxt_phase = (phase_ff == PH_LAST) ? PH_FIRST : phase_ff + 4'h1;
    end
    nxt_rst_cnt = rst_cnt_ff;
    if (!rst_pin_s) begin
      nxt_rst_cnt = 5'h00;
    end else if (tick_ff && rst_cnt_ff != RST_TICKS) begin
      nxt_rst_cnt = rst_cnt_ff + 5'h01;
    end
    // Release waits for a machine-cycle boundary so the bus restarts with whole phases.
    nxt_core_reset = (rst_pin_s && (rst_cnt_ff == RST_TICKS)) ||
      (core_reset_ff && !(tick_ff && phase_ff == PH_LAST));
    nxt_strap_held = strap_held_ff;
    nxt_strap_taken = strap_taken_ff;
    if (core_reset_ff || !strap_taken_ff) begin
      nxt_strap_held = strap_n_s;
      nxt_strap_taken = 1'b1;
    end
  end

  // With the lock bit set the strap is frozen as it stood at reset.
  assign ext_exec = i_lock_bit1 ? !strap_held_ff : !strap_n_s;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      // Starting at one gives phase 0 its full length after reset.
      div_ff <= 8'h01;
      tick_ff <= 1'b0;
      phase_ff <= PH_FIRST;
      rst_cnt_ff <= 5'h00;
      core_reset_ff <= 1'b0;
      strap_held_ff <= 1'b1;
      strap_taken_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      phase_ff <= nxt_phase;
      rst_cnt_ff <= nxt_rst_cnt;
      core_reset_ff <= nxt_core_reset;
      strap_held_ff <= nxt_strap_held;
      strap_taken_ff <= nxt_strap_taken;
    end
  end

  // Bus sequencer: a data access borrows the second half of one machine cycle
  // for its address and the first half of the next for its strobe.
  bus_state_t state_ff, nxt_state;
  xdata_req_t req_ff, nxt_req;
  logic [7:0] code_ff, nxt_code;
  logic code_valid_ff, nxt_code_valid;
  logic taken_ff, nxt_taken;
  logic done_ff, nxt_done;
  logic [7:0] rdata_ff, nxt_rdata;
  logic half_end;
  logic bus_run;

  assign half_end = tick_ff && (phase_ff == PH_HALF_END || phase_ff == PH_LAST);
  assign bus_run = !core_reset_ff && !i_program_pulse_in_mode;

  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_code = code_ff;
    nxt_code_valid = 1'b0;
    nxt_taken = 1'b0;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    case (state_ff)
      ST_FETCH: begin
        if (half_end && ext_exec && bus_run) begin
          nxt_code = pin_s.p0;
          nxt_code_valid = 1'b1;
        end
        if (tick_ff && phase_ff == PH_HALF_END && i_xreq.valid && bus_run) begin
          nxt_req = i_xreq;
          nxt_taken = 1'b1;
          nxt_state = ST_DADDR;
        end
      end
      ST_DADDR: begin
        if (tick_ff && phase_ff == PH_LAST) begin
          nxt_state = ST_DSTRB;
        end
      end
      ST_DSTRB: begin
        if (tick_ff && phase_ff == PH_HALF_END) begin
          if (!req_ff.write) begin
            nxt_rdata = pin_s.p0;
          end
          nxt_done = 1'b1;
          nxt_state = ST_FETCH;
        end
      end
      default: begin
        nxt_state = ST_FETCH;
      end
    endcase
    if (!bus_run && state_ff != ST_DSTRB) begin
      nxt_state = ST_FETCH;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_ff <= ST_FETCH;
      req_ff <= '0;
      code_ff <= 8'h00;
      code_valid_ff <= 1'b0;
      taken_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      code_ff <= nxt_code;
      code_valid_ff <= nxt_code_valid;
      taken_ff <= nxt_taken;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  // Pin drivers. An enable of one drives the pin; ports 1 to 3 rely on a
  // weak pullup whenever the enable is low.
  port_byte4_t out_ff, nxt_out;
  port_byte4_t oe_ff, nxt_oe;
  logic ale_ff, nxt_ale;
  logic ale_oe_ff, nxt_ale_oe;
  logic code_read_strobe_n_ff, nxt_code_read_strobe_n;
  flash_word_t flash_ff, nxt_flash;
  logic fwrite_ff, nxt_fwrite;
  logic ale_prev_ff, nxt_ale_prev;
  logic addr_phase;
  logic strb_phase;
  logic rw_phase;
  logic [7:0] p3_val;

  assign addr_phase = (phase_ff <= PH_ADDR_A_END) || (phase_ff >= PH_ALE_B && phase_ff <= PH_ADDR_B_END);
  assign strb_phase = (phase_ff >= PH_STRB_A && phase_ff <= PH_HALF_END) || (phase_ff >= PH_STRB_B);
  assign rw_phase = (state_ff == ST_DSTRB) && (phase_ff >= PH_RW_START) && (phase_ff <= PH_HALF_END);

  always_comb begin
    nxt_ale = 1'b0;
    nxt_code_read_strobe_n = 1'b1;
    nxt_out = i_latch;
    nxt_oe.p0 = ~i_latch.p0;
    nxt_oe.p1 = ~i_latch.p1;
    nxt_oe.p2 = ~i_latch.p2;
    p3_val = i_latch.p3 & {2'b11, i_p3_alt_out[5:0]};
    if (rw_phase && req_ff.write) begin
      p3_val[P3_WR_BIT] = 1'b0;
    end
    if (rw_phase && !req_ff.write) begin
      p3_val[P3_RD_BIT] = 1'b0;
    end
    nxt_out.p3 = p3_val;
    nxt_oe.p3 = ~p3_val;
    if (bus_run) begin
      // The pulse at phase 0 is dropped while a data strobe is under way.
      nxt_ale = (phase_ff == PH_ALE_A || phase_ff == PH_ALE_A_END) ? (state_ff != ST_DSTRB) :
        (phase_ff == PH_ALE_B || phase_ff == PH_ALE_B_END);
      if (state_ff == ST_FETCH && ext_exec) begin
        nxt_code_read_strobe_n = !strb_phase;
        nxt_out.p0 = addr_phase ? i_pc[7:0] : 8'h00;
        nxt_oe.p0 = addr_phase ? 8'hff : 8'h00;
        nxt_out.p2 = i_pc[15:8];
        nxt_oe.p2 = 8'hff;
      end
      if (state_ff == ST_DADDR || state_ff == ST_DSTRB) begin
        if (state_ff == ST_DADDR && phase_ff <= PH_ADDR_B_END) begin
          nxt_out.p0 = req_ff.addr[7:0];
          nxt_oe.p0 = 8'hff;
        end else begin
          nxt_out.p0 = req_ff.wdata;
          nxt_oe.p0 = req_ff.write ? 8'hff : 8'h00;
        end
        if (req_ff.wide) begin
          nxt_out.p2 = req_ff.addr[15:8];
          nxt_oe.p2 = 8'hff;
        end
      end
    end
    nxt_ale_oe = !i_program_pulse_in_mode;
    nxt_flash.addr_lo = pin_s.p1;
    nxt_flash.addr_hi = pin_s.p2;
    nxt_flash.data = pin_s.p0;
    nxt_ale_prev = ale_pin_s;
    nxt_fwrite = i_program_pulse_in_mode && !i_verify_mode && ale_prev_ff && !ale_pin_s;
    if (i_program_pulse_in_mode) begin
      nxt_oe.p1 = 8'h00;
      nxt_oe.p2 = 8'h00;
      nxt_out.p0 = i_flash_rdata;
      // Verify output is open drain and needs pullups on the board.
      nxt_oe.p0 = i_verify_mode ? ~i_flash_rdata : 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      out_ff <= {4{PORT_RESET}};
      oe_ff <= '0;
      ale_ff <= 1'b0;
      ale_oe_ff <= 1'b1;
      code_read_strobe_n_ff <= 1'b1;
      flash_ff <= '0;
      fwrite_ff <= 1'b0;
      ale_prev_ff <= 1'b1;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      ale_ff <= nxt_ale;
      ale_oe_ff <= nxt_ale_oe;
      code_read_strobe_n_ff <= nxt_code_read_strobe_n;
      flash_ff <= nxt_flash;
      fwrite_ff <= nxt_fwrite;
      ale_prev_ff <= nxt_ale_prev;
    end
  end

  // Registered status outputs.
  port_byte4_t pin_sync_ff;
  logic ext_exec_ff;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_sync_ff <= {4{PORT_RESET}};
      ext_exec_ff <= 1'b0;
    end else begin
      pin_sync_ff <= pin_s;
      ext_exec_ff <= ext_exec;
    end
  end

  assign o_pin_out = out_ff;
  assign o_pin_oe = oe_ff;
  assign o_ale = ale_ff;
  assign o_ale_oe = ale_oe_ff;
  assign o_code_read_strobe_n = code_read_strobe_n_ff;
  assign o_code_byte = code_ff;
  assign o_code_valid = code_valid_ff;
  assign o_xreq_taken = taken_ff;
  assign o_data_done = done_ff;
  assign o_rdata = rdata_ff;
  assign o_pin_sync = pin_sync_ff;
  assign o_core_reset = core_reset_ff;
  assign o_ext_exec = ext_exec_ff;
  assign o_flash = flash_ff;
  assign o_flash_write = fwrite_ff;

endmodule // port_and_external_memory_bus

// [bench/xbus_properties.sv]
`timescale 1ns/1ps
module xbus_properties #(
  parameter int OSC_DIV = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rst_pin,
  input wire logic i_program_pulse_in_mode,
  input wire xbus_pkg::port_byte4_t o_pin_out,
  input wire xbus_pkg::port_byte4_t o_pin_oe,
  input wire logic o_ale,
  input wire logic o_ale_oe,
  input wire logic o_code_read_strobe_n,
  input wire logic o_xreq_taken,
  input wire logic o_data_done,
  input wire logic o_core_reset,
  input wire logic o_ext_exec
);
  import xbus_pkg::*;
  localparam int ALE_HI = 2 * OSC_DIV;
  localparam int GAP = 4 * OSC_DIV;
  localparam int GAP_SKIP = 10 * OSC_DIV;
  localparam int STB_LO = 3 * OSC_DIV;
  localparam int MC = 12 * OSC_DIV;
  localparam int RST_SEEN = 22 * OSC_DIV;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n || i_program_pulse_in_mode || o_core_reset);

  ale_width_a: assert property ($rose(o_ale) |-> ##ALE_HI $fell(o_ale))
    else $error("address strobe width wrong");
  ale_gap_a: assert property ($fell(o_ale) |-> (##GAP o_ale) or (##GAP_SKIP o_ale))
    else $error("address strobe spacing wrong");
  code_strobe_a: assert property ($fell(o_code_read_strobe_n) |->
    ($past(o_ale, OSC_DIV + 1) && !$past(o_ale, OSC_DIV)) ##STB_LO o_code_read_strobe_n)
    else $error("code strobe placement wrong");
  int_exec_a: assert property (!o_ext_exec [*2] |-> o_code_read_strobe_n)
    else $error("code strobe in internal mode");
  wr_strobe_a: assert property (!o_pin_out.p3[6] && o_pin_oe.p3[6] |-> !o_ale && o_code_read_strobe_n)
    else $error("write strobe overlaps fetch");
  rd_strobe_a: assert property (!o_pin_out.p3[7] && o_pin_oe.p3[7] |-> !o_ale && o_code_read_strobe_n)
    else $error("read strobe overlaps fetch");
  xfer_time_a: assert property (o_xreq_taken |-> ##MC o_data_done)
    else $error("data access length wrong");
  addr_drive_a: assert property (o_ale && o_ext_exec |-> o_pin_oe.p0 == 8'hff)
    else $error("port 0 not driving address");
  program_pulse_in_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_program_pulse_in_mode [*2] |-> !o_ale_oe)
    else $error("latch pin driven in programming");
  core_rst_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(o_core_reset) |-> $past(i_rst_pin, RST_SEEN))
    else $error("core reset after short pin pulse");

  cover property (o_xreq_taken);
  cover property ($fell(o_code_read_strobe_n));
  cover property (@(posedge i_clk_sys) $rose(o_core_reset));
endmodule // xbus_properties

bind port_and_external_memory_bus xbus_properties #(.OSC_DIV(OSC_DIV)) xbus_properties_i (
  .i_clk_sys, .i_rst_n, .i_rst_pin, .i_program_pulse_in_mode, .o_pin_out, .o_pin_oe, .o_ale, .o_ale_oe,
  .o_code_read_strobe_n, .o_xreq_taken, .o_data_done, .o_core_reset, .o_ext_exec);

// [bench/ext_mem_model.sv]
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_ale,
  input wire logic i_code_strobe_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic [7:0] i_p0_out,
  input wire logic [7:0] i_p0_oe,
  input wire logic [7:0] i_p2,
  output logic [7:0] o_p0
);
  logic [15:0] addr_ff;
  logic [7:0] last_ff;
  logic [7:0] wbuf_ff;
  logic ale_ff;
  logic wr_ff;
  logic [7:0] val;
  logic [7:0] dmem [logic [15:0]];

  always @(posedge i_clk_sys) begin
    ale_ff <= i_ale;
    wr_ff <= i_wr_n;
    last_ff <= o_p0;
    if (ale_ff && !i_ale) begin
      addr_ff <= {i_p2, i_p0_out};
    end
    if (!i_wr_n) begin
      wbuf_ff <= o_p0;
    end
    if (!wr_ff && i_wr_n) begin
      dmem[addr_ff] = wbuf_ff;
    end
  end

  // An undriven bus shows a changing pattern so that a stale value never reads as good.
  always @* begin
    val = ~last_ff;
    if (!i_code_strobe_n) begin
      val = addr_ff[7:0] ^ addr_ff[15:8] ^ 8'h5a;
    end else if (!i_rd_n) begin
      val = dmem.exists(addr_ff) ? dmem[addr_ff] : 8'h00;
    end
    o_p0 = (i_p0_oe & i_p0_out) | (~i_p0_oe & val);
  end
endmodule // ext_mem_model

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import xbus_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rst_pin = 1'b0;
  logic strap_n = 1'b1;
  logic lock = 1'b0;
  logic program_pulse_in = 1'b0;
  logic verify = 1'b0;
  logic ale_ext = 1'b1;
  logic [7:0] alt = 8'hff;
  logic [7:0] frd = 8'h00;
  logic [15:0] pc = 16'hf3a5;
  port_byte4_t latch = 32'hffffffff;
  port_byte4_t ext = 32'hffffffff;
  xdata_req_t xreq = '0;
  port_byte4_t pin, pout, poe, psync, res;
  logic ale, ale_oe, strobe_n, cvalid, taken, done, creset, exec, fwr;
  logic [7:0] cbyte, rdata, mdl_p0;
  flash_word_t flash;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;
  assign res = (poe & pout) | (~poe & ext);
  assign pin = {res[31:8], program_pulse_in ? res[7:0] : mdl_p0};

  port_and_external_memory_bus port_and_external_memory_bus_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_rst_pin(rst_pin), .i_external_fetch_strap_n(strap_n),
    .i_lock_bit1(lock), .i_program_pulse_in_mode(program_pulse_in), .i_verify_mode(verify), .i_latch(latch),
    .i_p3_alt_out(alt), .i_pc(pc), .i_xreq(xreq), .i_pin(pin), .i_ale_pin(ale_oe ? ale : ale_ext),
    .i_flash_rdata(frd), .o_pin_out(pout), .o_pin_oe(poe), .o_ale(ale), .o_ale_oe(ale_oe),
    .o_code_read_strobe_n(strobe_n), .o_code_byte(cbyte), .o_code_valid(cvalid),
    .o_xreq_taken(taken), .o_data_done(done), .o_rdata(rdata), .o_pin_sync(psync),
    .o_core_reset(creset), .o_ext_exec(exec), .o_flash(flash), .o_flash_write(fwr));

  ext_mem_model ext_mem_model_i (
    .i_clk_sys(clk), .i_ale(ale), .i_code_strobe_n(strobe_n), .i_wr_n(pin.p3[6]),
    .i_rd_n(pin.p3[7]), .i_p0_out(pout.p0), .i_p0_oe(poe.p0), .i_p2(pin.p2), .o_p0(mdl_p0));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap_n = s;
    tick(12);
    rst_n = 1'b1;
    tick(8);
  endtask

  task automatic t_ports();
    do_reset(1'b1);
    latch = {8'hff, 8'hff, 8'h3c, 8'h0f};
    alt = 8'hfd;
    ext.p3 = 8'hd3;
    tick(12);
    while (ale) tick(1);
    tick(2);
    chk("p0 oe", 8'hf0, poe.p0);
    chk("p1 oe", 8'hc3, poe.p1);
    chk("p1 in", 8'h3c, psync.p1);
    chk("p3 oe", 8'h02, poe.p3);
    chk("p3 in", 8'hd1, psync.p3);
    chk("exec", 1'b0, exec);
    latch = '1;
    alt = 8'hff;
    ext = '1;
  endtask

  task automatic t_fetch();
    int nr, nf, nv;
    logic pa, ps;
    do_reset(1'b0);
    nr = 0;
    nf = 0;
    nv = 0;
    repeat (192) begin
      pa = ale;
      ps = strobe_n;
      tick(1);
      if (ale && !pa) begin
        nr++;
        chk("p0 addr", 16'hffa5, {poe.p0, pout.p0});
        chk("p2 addr", 16'hfff3, {poe.p2, pout.p2});
      end
      if (!strobe_n && ps) nf++;
      if (cvalid) begin
        nv++;
        chk("code", 8'ha5 ^ 8'hf3 ^ 8'h5a, cbyte);
      end
    end
    chk("ale count", 8, nr);
    chk("strobe count", 8, nf);
    chk("code count", 8, nv);
  endtask

  task automatic t_xfer(input logic wr, input logic wide, input logic [15:0] a, input logic [7:0] d);
    int n, nr, nf, dn;
    logic ws, rs, pa, ps;
    xreq = {1'b1, wr, wide, a, d};
    n = 0;
    while (!taken && n < 100) begin
      tick(1);
      n++;
    end
    xreq.valid = 1'b0;
    nr = 0;
    nf = 0;
    dn = 0;
    ws = 1'b0;
    rs = 1'b0;
    for (int i = 1; i < 52; i++) begin
      pa = ale;
      ps = strobe_n;
      tick(1);
      if (i == 2) begin
        chk("p0 addr", {8'hff, a[7:0]}, {poe.p0, pout.p0});
        chk("p2", wide ? {8'hff, a[15:8]} : {~latch.p2, latch.p2}, {poe.p2, pin.p2});
      end
      if (i > 2 && i < 47 && ale && !pa) nr++;
      if (i > 2 && i < 47 && !strobe_n && ps) nf++;
      ws |= !pin.p3[6];
      rs |= !pin.p3[7];
      if (done) begin
        dn++;
        if (!wr) chk("rdata", d, rdata);
      end
    end
    chk("ale skip", 0, nr);
    chk("strobe skip", 0, nf);
    chk("wr strobe", wr, ws);
    chk("rd strobe", !wr, rs);
    chk("done", 1, dn);
  endtask

  task automatic t_creset();
    logic seen;
    lock = 1'b1;
    seen = 1'b0;
    rst_pin = 1'b1;
    repeat (60) begin
      tick(1);
      seen |= creset;
    end
    rst_pin = 1'b0;
    repeat (10) begin
      tick(1);
      seen |= creset;
    end
    chk("short pulse", 0, seen);
    rst_pin = 1'b1;
    tick(120);
    chk("core reset", 1, creset);
    rst_pin = 1'b0;
    tick(60);
    chk("core release", 0, creset);
    strap_n = 1'b1;
    tick(10);
    chk("strap held", 1, exec);
    rst_pin = 1'b1;
    tick(120);
    rst_pin = 1'b0;
    tick(10);
    chk("strap resampled", 0, exec);
  endtask

  task automatic t_flash();
    logic seen;
    program_pulse_in = 1'b1;
    ext = {8'hff, 8'h07, 8'h34, 8'h4b};
    tick(8);
    chk("ale oe", 0, ale_oe);
    seen = 1'b0;
    ale_ext = 1'b0;
    for (int i = 0; i < 16; i++) begin
      tick(1);
      if (i == 8) ale_ext = 1'b1;
      if (fwr) begin
        seen = 1'b1;
        chk("flash word", 24'h07344b, flash);
      end
    end
    chk("flash write", 1, seen);
    ext.p0 = 8'hff;
    verify = 1'b1;
    frd = 8'h96;
    tick(8);
    chk("verify oe", 8'h69, poe.p0);
    chk("verify pin", 8'h96, pin.p0);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    t_ports();
    t_fetch();
    t_xfer(1'b1, 1'b1, 16'h8a31, 8'hc6);
    t_xfer(1'b0, 1'b1, 16'h8a31, 8'hc6);
    latch.p2 = 8'h5e;
    t_xfer(1'b1, 1'b0, 16'h0077, 8'h39);
    t_xfer(1'b0, 1'b0, 16'h0077, 8'h39);
    t_creset();
    t_flash();
    close_out();
  end
endmodule // testbench
